// *** hw/adc_conv_ctrl.sv ***
/*
 * Conversion sequencing and analog front-end control with an AXI4-Lite
 * register slave and a masked, sticky interrupt.
 * Assumes one 200 MHz clock, synchronous active-low reset, and that
 * analog controls are consumed by front-end cells outside this block.
 */
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"
// Functional notes
// - Continuous mode spaces ready falls by the rate's period, same both modes.
// - First conversion starts 28.5 (normal) or 105 (turbo) cycles after trigger.
// - Single-shot ready falls a tabulated whole cycle count after trigger.
// - Oscillator cycle is 1.024 MHz normal, 2.048 MHz turbo.
// - Rate changes apply next conversion; no results discarded.
// - Three-bit current code picks one of seven magnitudes; zero disables.
// - Two sources routed independently; same pin allowed.
// - Sources need 200 us after a nonzero code before use.
// - In single-shot, sources stay powered between conversions.
// - Sleep command powers sources down regardless of code.
// - Bias on whenever code nonzero and not asleep, even with no routing.
// - Burn-out sources into positive input and out of negative input.
// - Monitor inputs force amplifier bypass and unity gain.
// - Supply monitor code uses internal reference.
// - Reference monitor code uses internal reference.
// - Supply-referenced inputs bypass amplifier; gain above four clamps to four.
// - Sleep lets a running conversion finish first.
module adc_conv_ctrl
	import adc_ctrl_pkg::*;
#(
	parameter int EXC_START_CYC = `EXC_START_US * `BUS_CLK_MHZ
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic data_ready_n,
	output logic irq,
	output logic conv_active,
	output logic exc_bias_en,
	output logic [6:0] exc_level,
	output logic [2:0] first_current_route,
	output logic [2:0] second_current_route,
	output logic exc_ready,
	output logic burnout_src_en,
	output logic burnout_sink_en,
	output logic [3:0] input_select,
	output logic amp_bypass,
	output logic [2:0] gain_eff,
	output logic [1:0] ref_eff
);
	localparam int TW = 17;
	localparam int EW = $clog2(EXC_START_CYC + 1);

	if (EXC_START_CYC < 1) begin : g_chk
		$error("excitation start-up count must be positive");
	end

	seq_state_type state_r, state_nxt;
	logic [31:0] mode_r, afe_r, mode_nxt, afe_nxt;
	logic [`IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_stat_nxt;
	logic [4:0] awaddr_r;
	logic [31:0] wdata_r, wmask_r, wmask;
	logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r, rd_val;
	logic dr_r, sleep_pend_r, asleep_r, exc_ready_r;
	logic wr_go, rd_go, wr_hit, rd_hit;
	logic cmd_wr, trig, sleep_cmd, read_ack;
	logic cont_mode, turbo;
	logic [2:0] rate;
	logic [2:0] exc_code;
	logic [2:0] gain_cfg;
	logic [1:0] ref_cfg;
	logic sysmon, avss_rng, open_en;
	logic tick, t_load, t_last, t_done;
	logic [TW-1:0] t_val;
	logic exc_on, exc_load, exc_done;
	logic [EW-1:0] exc_val;

	// Register fields
	assign cont_mode = mode_r[`MODE_CONT];
	assign turbo = mode_r[`MODE_TURBO];
	assign rate = mode_r[`MODE_RATE_HI:`MODE_RATE_LO];
	assign exc_code = afe_r[`AFE_EXC_HI:`AFE_EXC_LO];
	assign open_en = afe_r[`AFE_OPEN];
	assign input_select = afe_r[`AFE_SEL_HI:`AFE_SEL_LO];
	assign gain_cfg = afe_r[`AFE_GAIN_HI:`AFE_GAIN_LO];
	assign ref_cfg = afe_r[`AFE_REF_HI:`AFE_REF_LO];

	// Conversion period per rate; illegal code runs the fastest
	function automatic logic [TW-1:0] cont_len(input logic [2:0] r);
		unique case (r)
			3'h0: cont_len = `CONT_0;
			3'h1: cont_len = `CONT_1;
			3'h2: cont_len = `CONT_2;
			3'h3: cont_len = `CONT_3;
			3'h4: cont_len = `CONT_4;
			3'h5: cont_len = `CONT_5;
			default: cont_len = `CONT_6;
		endcase
	endfunction : cont_len

	// Single-shot latency per rate and clock mode
	function automatic logic [TW-1:0] shot_len(input logic [2:0] r,
			input logic t);
		unique case (r)
			3'h0: shot_len = t ? `SHOTT_0 : `SHOTN_0;
			3'h1: shot_len = t ? `SHOTT_1 : `SHOTN_1;
			3'h2: shot_len = t ? `SHOTT_2 : `SHOTN_2;
			3'h3: shot_len = t ? `SHOTT_3 : `SHOTN_3;
			3'h4: shot_len = t ? `SHOTT_4 : `SHOTN_4;
			3'h5: shot_len = t ? `SHOTT_5 : `SHOTN_5;
			default: shot_len = t ? `SHOTT_6 : `SHOTN_6;
		endcase
	endfunction : shot_len

	// Half-cycle tick of the oscillator
	osc_tick_gen u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.turbo(turbo),
		.tick(tick)
	);

	// Conversion timer, counting half oscillator cycles
	conv_timer #(.W(TW)) u_conv (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(t_load),
		.load_val(t_val),
		.tick(tick),
		.busy(),
		.last(t_last),
		.done(t_done)
	);

	// Excitation start-up timer in bus cycles
	conv_timer #(.W(EW)) u_exc (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(exc_load),
		.load_val(exc_val),
		.tick(1'b1),
		.busy(),
		.last(),
		.done(exc_done)
	);

	// AXI4-Lite write path: address and data in either order
	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	assign wr_go = aw_got_r && w_got_r && !bvalid_r;
	assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
		{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	assign wr_hit = (awaddr_r == `OFS_MODE) || (awaddr_r == `OFS_CMD) ||
		(awaddr_r == `OFS_AFE) || (awaddr_r == `OFS_IRQ_STAT) ||
		(awaddr_r == `OFS_IRQ_MASK);
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 5'h0;
			wdata_r <= 32'h0;
			wmask_r <= 32'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end else if (wr_go)
				aw_got_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wmask_r <= wmask;
			end else if (wr_go)
				w_got_r <= 1'b0;
		end
	end

	// Write response; unmapped offsets answer with a slave error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_hit ? 2'h0 : 2'h2;
		end else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	// Command pulses, only on bytes actually written
	assign cmd_wr = wr_go && (awaddr_r == `OFS_CMD);
	assign trig = cmd_wr && wmask_r[`CMD_TRIG] && wdata_r[`CMD_TRIG];
	assign sleep_cmd = cmd_wr && wmask_r[`CMD_SLEEP] &&
		wdata_r[`CMD_SLEEP];
	assign read_ack = cmd_wr && wmask_r[`CMD_READ_ACK] &&
		wdata_r[`CMD_READ_ACK];

	// Byte-lane merge of configuration writes
	assign mode_nxt = (wr_go && awaddr_r == `OFS_MODE) ?
		((mode_r & ~wmask_r) | (wdata_r & wmask_r)) : mode_r;
	assign afe_nxt = (wr_go && awaddr_r == `OFS_AFE) ?
		((afe_r & ~wmask_r) | (wdata_r & wmask_r)) : afe_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= `MODE_RESET;
			afe_r <= `AFE_RESET;
		end else begin
			mode_r <= mode_nxt;
			afe_r <= afe_nxt;
		end
	end

	// Read path
	assign rd_go = s_axi_arvalid && !rvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign rd_hit = (s_axi_araddr == `OFS_MODE) ||
		(s_axi_araddr == `OFS_CMD) || (s_axi_araddr == `OFS_AFE) ||
		(s_axi_araddr == `OFS_STAT) || (s_axi_araddr == `OFS_EFF) ||
		(s_axi_araddr == `OFS_IRQ_STAT) || (s_axi_araddr == `OFS_IRQ_MASK);
	assign rd_val =
		(s_axi_araddr == `OFS_MODE) ? mode_r :
		(s_axi_araddr == `OFS_AFE) ? afe_r :
		(s_axi_araddr == `OFS_STAT) ? {26'h0, exc_bias_en, exc_ready_r,
			asleep_r, dr_r, sleep_pend_r, conv_active} :
		(s_axi_araddr == `OFS_EFF) ? {26'h0, ref_eff, amp_bypass,
			gain_eff} :
		(s_axi_araddr == `OFS_IRQ_STAT) ? {30'h0, irq_stat_r} :
		(s_axi_araddr == `OFS_IRQ_MASK) ? {30'h0, irq_mask_r} : 32'h0;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= 2'h0;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_val;
			rresp_r <= rd_hit ? 2'h0 : 2'h2;
		end else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	// Sequencer: trigger restarts, sleep waits for conversion end
	always_comb begin
		state_nxt = state_r;
		t_load = 1'b0;
		t_val = cont_len(rate) << 1;
		if (trig) begin
			t_load = 1'b1;
			state_nxt = cont_mode ? ST_DELAY : ST_SHOT;
			if (cont_mode)
				t_val = turbo ? `START_TURBO : `START_NORMAL;
			else
				t_val = shot_len(rate, turbo) << 1;
		end else begin
			unique case (state_r)
				ST_IDLE: if (sleep_cmd) state_nxt = ST_SLEEP;
				ST_SLEEP: state_nxt = ST_SLEEP;
				ST_DELAY: begin
					if (t_done && sleep_pend_r)
						state_nxt = ST_SLEEP;
					else if (t_done) begin
						t_load = 1'b1;
						state_nxt = ST_CONV;
					end
				end
				ST_CONV: begin
					if (t_done && (sleep_pend_r || sleep_cmd))
						state_nxt = ST_SLEEP;
					else if (t_done && !cont_mode)
						state_nxt = ST_IDLE;
					else if (t_done)
						t_load = 1'b1;
				end
				ST_SHOT: begin
					if (t_done)
						state_nxt = (sleep_pend_r || sleep_cmd) ?
							ST_SLEEP : ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Sleep request and power state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_pend_r <= 1'b0;
			asleep_r <= 1'b0;
		end else begin
			sleep_pend_r <= (sleep_pend_r || sleep_cmd) && !trig &&
				(state_nxt != ST_SLEEP) && (state_nxt != ST_IDLE);
			asleep_r <= (state_nxt == ST_SLEEP);
		end
	end

	assign conv_active = (state_r == ST_DELAY) || (state_r == ST_CONV) ||
		(state_r == ST_SHOT);

	// Ready flag: set at conversion end wins over any clear
	always_ff @(posedge aclk) begin
		if (!aresetn)
			dr_r <= 1'b0;
		else if (t_done && (state_r == ST_CONV || state_r == ST_SHOT))
			dr_r <= 1'b1;
		else if (read_ack || trig || (state_r == ST_CONV && t_last))
			dr_r <= 1'b0;
	end
	assign data_ready_n = !dr_r;

	// Excitation sources: held on between conversions, off in sleep
	assign exc_on = (exc_code != 3'h0) && !asleep_r;
	assign exc_bias_en = exc_on;
	assign first_current_route = exc_on ?
		afe_r[`AFE_R1_HI:`AFE_R1_LO] : 3'h0;
	assign second_current_route = exc_on ?
		afe_r[`AFE_R2_HI:`AFE_R2_LO] : 3'h0;

	// One select line per magnitude, lowest current first
	for (genvar i = 0; i < 7; i++) begin : g_level
		assign exc_level[i] = exc_on && (exc_code == 3'(i + 1));
	end

	// Start-up wait restarts on a new nonzero code; held loaded while asleep with a nonzero code
	// so a count left running from an earlier code cannot end it early
	assign exc_val = EW'(EXC_START_CYC);
	assign exc_load = (afe_nxt[`AFE_EXC_HI:`AFE_EXC_LO] != 3'h0) &&
		(!exc_on || (afe_nxt[`AFE_EXC_HI:`AFE_EXC_LO] != exc_code));

	always_ff @(posedge aclk) begin
		if (!aresetn)
			exc_ready_r <= 1'b0;
		else if (!exc_on || exc_load)
			exc_ready_r <= 1'b0;
		else if (exc_done)
			exc_ready_r <= 1'b1;
	end
	assign exc_ready = exc_ready_r;

	// Burn-out sources follow the selected input pair
	assign burnout_src_en = open_en && !asleep_r;
	assign burnout_sink_en = open_en && !asleep_r;

	// Forced front-end settings for monitor and supply-referenced inputs
	assign sysmon = (input_select == `SEL_REF_MON) ||
		(input_select == `SEL_SUP_MON);
	assign avss_rng = (input_select >= `SEL_AVSS_LO) &&
		(input_select <= `SEL_AVSS_HI);
	assign amp_bypass = sysmon || avss_rng || afe_r[`AFE_SKIP];
	assign gain_eff = sysmon ? `GAIN_ONE :
		(avss_rng && gain_cfg > `GAIN_FOUR) ? `GAIN_FOUR : gain_cfg;
	assign ref_eff = sysmon ? `REF_INTERNAL : ref_cfg;

	// Sticky interrupt status, set wins over write-one clear
	assign irq_stat_nxt = {exc_done && exc_on,
		t_done && (state_r == ST_CONV || state_r == ST_SHOT)} |
		(irq_stat_r & ~((wr_go && awaddr_r == `OFS_IRQ_STAT) ?
		(wdata_r[`IRQ_W-1:0] & wmask_r[`IRQ_W-1:0]) : 2'h0));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= 2'h0;
			irq_mask_r <= 2'h0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			if (wr_go && awaddr_r == `OFS_IRQ_MASK && wmask_r[0])
				irq_mask_r <= wdata_r[`IRQ_W-1:0];
		end
	end
	assign irq = |(irq_stat_r & irq_mask_r);

	// Checks
	sequence conv_end_s;
		(state_r == ST_CONV || state_r == ST_SHOT) && t_done;
	endsequence

	sequence ready_low_s;
		!data_ready_n;
	endsequence

	a_ready_falls_end: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(data_ready_n) |-> $past(t_done))
		else $error("ready fell without a conversion end");
	a_end_sets_ready: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_end_s |=> ready_low_s)
		else $error("conversion end did not lower ready");
	a_delay_then_conv: assert property (@(posedge aclk) disable iff (!aresetn)
		state_r == ST_DELAY && t_done && !trig && !sleep_pend_r |=>
		state_r == ST_CONV) else $error("start delay did not lead on");
	a_sleep_waits_end: assert property (@(posedge aclk) disable iff (!aresetn)
		state_r == ST_CONV && !t_done && !trig |=> state_r != ST_SLEEP)
		else $error("sleep cut a conversion short");
	a_sleep_exc_off: assert property (@(posedge aclk) disable iff (!aresetn)
		asleep_r |-> !exc_bias_en && exc_level == 7'h0)
		else $error("excitation powered in sleep");
	a_bias_with_code: assert property (@(posedge aclk) disable iff (!aresetn)
		!asleep_r && exc_code != 3'h0 |-> exc_bias_en && $onehot(exc_level))
		else $error("excitation bias missing");
	a_monitor_forced: assert property (@(posedge aclk) disable iff (!aresetn)
		sysmon |-> amp_bypass && gain_eff == `GAIN_ONE &&
		ref_eff == `REF_INTERNAL) else $error("monitor not forced");
	a_avss_clamp_gain: assert property (@(posedge aclk) disable iff (!aresetn)
		avss_rng |-> amp_bypass && gain_eff <= `GAIN_FOUR)
		else $error("supply-referenced gain not clamped");
	a_burnout_pair: assert property (@(posedge aclk) disable iff (!aresetn)
		open_en && !asleep_r |-> burnout_src_en && burnout_sink_en)
		else $error("burn-out pair not enabled");
endmodule : adc_conv_ctrl
`default_nettype wire

// *** include/adc_ctrl_defines.svh ***
/*
 * Offsets, field positions, reset values and timing counts for the
 * converter sequencing and front-end control block.
 * Assumes a 200 MHz bus clock; start delays are in half oscillator cycles, period and latency tables in whole cycles.
 */
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// Register byte offsets
`define OFS_MODE 5'h00
`define OFS_CMD 5'h04
`define OFS_AFE 5'h08
`define OFS_STAT 5'h0c
`define OFS_EFF 5'h10
`define OFS_IRQ_STAT 5'h14
`define OFS_IRQ_MASK 5'h18

// Mode register fields
`define MODE_CONT 0
`define MODE_TURBO 1
`define MODE_RATE_LO 2
`define MODE_RATE_HI 4
`define MODE_RESET 32'h0000_0000

// Command register bits (write-only pulses)
`define CMD_TRIG 0
`define CMD_SLEEP 1
`define CMD_READ_ACK 2

// Front-end register fields
`define AFE_EXC_LO 0
`define AFE_EXC_HI 2
`define AFE_R1_LO 3
`define AFE_R1_HI 5
`define AFE_R2_LO 6
`define AFE_R2_HI 8
`define AFE_OPEN 9
`define AFE_SEL_LO 10
`define AFE_SEL_HI 13
`define AFE_SKIP 14
`define AFE_GAIN_LO 15
`define AFE_GAIN_HI 17
`define AFE_REF_LO 18
`define AFE_REF_HI 19
`define AFE_RESET 32'h0000_0000

// Input selection codes and forced settings
`define SEL_AVSS_LO 4'h8
`define SEL_AVSS_HI 4'hb
`define SEL_REF_MON 4'hc
`define SEL_SUP_MON 4'hd
`define GAIN_ONE 3'h0
`define GAIN_FOUR 3'h2
`define REF_INTERNAL 2'h0

// Interrupt bits
`define IRQ_CONV 0
`define IRQ_EXC 1
`define IRQ_W 2

// Oscillator half-cycle tick: rate in kHz against bus clock in kHz
`define BUS_CLK_KHZ 18'h30d40
`define HALF_KHZ_NORMAL 18'h00800
`define HALF_KHZ_TURBO 18'h01000

// Start delay after a trigger, in half oscillator cycles (28.5 / 105)
`define START_NORMAL 17'h00039
`define START_TURBO 17'h000d2

// Excitation start-up time
`define EXC_START_US 200
`define BUS_CLK_MHZ 200

// Continuous conversion periods, oscillator cycles
`define CONT_0 17'd51192
`define CONT_1 17'd22780
`define CONT_2 17'd11532
`define CONT_3 17'd5916
`define CONT_4 17'd3116
`define CONT_5 17'd1724
`define CONT_6 17'd1036
// Single-shot latencies, normal mode
`define SHOTN_0 17'd51213
`define SHOTN_1 17'd22805
`define SHOTN_2 17'd11557
`define SHOTN_3 17'd5941
`define SHOTN_4 17'd3141
`define SHOTN_5 17'd1749
`define SHOTN_6 17'd1061
// Single-shot latencies, turbo mode
`define SHOTT_0 17'd51217
`define SHOTT_1 17'd22809
`define SHOTT_2 17'd11561
`define SHOTT_3 17'd5945
`define SHOTT_4 17'd3145
`define SHOTT_5 17'd1753
`define SHOTT_6 17'd1065

`endif

// *** include/adc_ctrl_pkg.sv ***
/*
 * Types shared by the converter control design.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package adc_ctrl_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_DELAY, ST_CONV, ST_SHOT, ST_SLEEP
	} seq_state_type;
endpackage : adc_ctrl_pkg

// *** hw/osc_tick_gen.sv ***
/*
 * Oscillator half-cycle tick generator derived from the bus clock.
 * Assumes a free-running bus clock at the rate in the defines header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"
module osc_tick_gen (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic turbo,
	output logic tick
);
	logic [17:0] acc_r;
	logic [17:0] step;
	logic [18:0] sum;

	// Exact fractional rate: step modulo bus clock
	assign step = turbo ? `HALF_KHZ_TURBO : `HALF_KHZ_NORMAL;
	assign sum = {1'b0, acc_r} + {1'b0, step};
	assign tick = (sum >= {1'b0, `BUS_CLK_KHZ});

	always_ff @(posedge aclk) begin
		if (!aresetn)
			acc_r <= 18'h0;
		else if (tick)
			acc_r <= 18'(sum - {1'b0, `BUS_CLK_KHZ});
		else
			acc_r <= sum[17:0];
	end

	a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
		tick |=> !tick) else $error("oscillator ticks back to back");
endmodule : osc_tick_gen
`default_nettype wire

// *** hw/conv_timer.sv ***
/*
 * Loadable down counter stepped by a tick; flags its last step and end.
 * Assumes load and tick are synchronous to aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module conv_timer #(
	parameter int W = 17
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic tick,
	output logic busy,
	output logic last,
	output logic done
);
	logic [W-1:0] cnt_r;

	if (W < 2) begin : g_chk
		$error("conv_timer width too small");
	end

	// Count flags
	assign busy = (cnt_r != '0);
	assign last = (cnt_r == W'(1));
	assign done = last && tick && !load;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt_r <= '0;
		else if (load)
			cnt_r <= load_val;
		else if (tick && busy)
			cnt_r <= cnt_r - W'(1);
	end

	a_done_once: assert property (@(posedge aclk) disable iff (!aresetn)
		done |=> !busy) else $error("timer still busy after end");
endmodule : conv_timer
`default_nettype wire

// *** dv/axil_host.sv ***
/*
 * Host model: an AXI4-Lite master issuing register commands.
 * Assumes the bench clock; tasks are called by the testbench.
 */
`timescale 1ns/1ps
`default_nettype none
module axil_host (
	input wire logic aclk,
	output logic [4:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [4:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// Idle bus at time zero
	initial begin
		s_axi_awaddr = 5'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 5'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
	end

	// Write: address and data together, each released when taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		r = 2'h3; // Left at 3 on timeout
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	// Read one word
	task automatic rd(input logic [4:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int k;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r = 2'h3;
		d = 32'hx;
		for (k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : rd
endmodule : axil_host
`default_nettype wire

// *** dv/adc_conversion_and_frontend_ctrl_tb.sv ***
/*
 * Self-checking bench for the converter control block.
 * Assumes the host model and a shortened excitation start-up count.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"
module adc_conversion_and_frontend_ctrl_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [4:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, w, lfsr_r;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, ref_eff, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, irq, conv_active, exc_ready;
	logic data_ready_n, exc_bias_en, burnout_src_en, burnout_sink_en;
	logic amp_bypass;
	logic [6:0] exc_level;
	logic [2:0] first_current_route, second_current_route, gain_eff, c;
	logic [3:0] input_select, s;
	int num_errors = 0;
	int comparisons = 0;
	int i, k, e;

	adc_conv_ctrl #(.EXC_START_CYC(20)) DUT (.*);
	axil_host host (.*);

	always #2.5 aclk = ~aclk;

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	// Effective {reference, bypass, gain} for a selection
	function automatic logic [5:0] eff(input logic [3:0] sl, input logic sk,
		input logic [2:0] g, input logic [1:0] f);
		if (sl == `SEL_REF_MON || sl == `SEL_SUP_MON) begin
			return {`REF_INTERNAL, 1'b1, `GAIN_ONE};
		end
		if (sl >= `SEL_AVSS_LO && sl <= `SEL_AVSS_HI) begin
			return {f, 1'b1, (g > `GAIN_FOUR) ? `GAIN_FOUR : g};
		end
		return {f, sk, g};
	endfunction : eff

	task automatic stop_test;
		if (num_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] y);
		comparisons++;
		if (y !== x) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, x, y);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		logic [1:0] rr;
		host.wr(a, v, rr);
		chk("bresp", 32'h0, {30'h0, rr});
		if (rr === 2'h3) begin
			stop_test();
		end
	endtask : wr

	task automatic rdc(input logic [4:0] a, input logic [31:0] x,
		input string nm);
		logic [31:0] v;
		logic [1:0] rr;
		host.rd(a, v, rr);
		chk(nm, x, v);
		if (rr === 2'h3) begin
			stop_test();
		end
	endtask : rdc

	// Main sequence
	initial begin
		lfsr_r = 32'had54f9de;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		chk("ready_n", 32'h1, {31'h0, data_ready_n});
		rdc(`OFS_MODE, `MODE_RESET, "mode");
		rdc(`OFS_AFE, `AFE_RESET, "afe");
		rdc(`OFS_STAT, 32'h0, "stat");
		host.rd(5'h1c, d, r);
		chk("unmapped", 32'h2, {30'h0, r});
		// Every current code and input code, random routing and gain
		for (i = 0; i < 24; i++) begin
			lfsr_r = lfsr(lfsr_r);
			c = i[2:0];
			s = (i < 16) ? i[3:0] : lfsr_r[13:10];
			w = {12'h0, lfsr_r[19:14], s, lfsr_r[9:3], c};
			if (i == 5) begin
				w[8:6] = w[5:3];
			end
			wr(`OFS_AFE, w & 32'hfffffe07);
			wr(`OFS_AFE, w);
			chk("level", {25'h0, (c == 3'h0) ? 7'h0 : 7'h1 << (c - 3'h1)},
				{25'h0, exc_level});
			chk("bias", {31'h0, c != 3'h0}, {31'h0, exc_bias_en});
			chk("route1", {29'h0, (c != 3'h0) ? w[5:3] : 3'h0},
				{29'h0, first_current_route});
			chk("route2", {29'h0, (c != 3'h0) ? w[8:6] : 3'h0},
				{29'h0, second_current_route});
			chk("burnout", {30'h0, {2{w[9]}}},
				{30'h0, burnout_src_en, burnout_sink_en});
			chk("select", {28'h0, s}, {28'h0, input_select});
			chk("eff", {26'h0, eff(s, w[14], w[17:15], w[19:18])},
				{26'h0, ref_eff, amp_bypass, gain_eff});
			rdc(`OFS_EFF, {26'h0, eff(s, w[14], w[17:15], w[19:18])},
				"eff_reg");
		end
		// Excitation start-up and its interrupt
		wr(`OFS_AFE, 32'h0);
		wr(`OFS_IRQ_STAT, 32'h3);
		wr(`OFS_AFE, 32'h3);
		for (k = 0; k < 100 && exc_ready !== 1'b1; k++) @(posedge aclk);
		chk("exc_wait", 32'h1, {31'h0, k >= 16 && k <= 21});
		rdc(`OFS_IRQ_STAT, 32'h2, "irq_stat");
		chk("irq_masked", 32'h0, {31'h0, irq});
		wr(`OFS_IRQ_MASK, 32'h2);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`OFS_IRQ_STAT, 32'h2);
		chk("irq_clear", 32'h0, {31'h0, irq});
		// Sleep during the start delay, normal then turbo
		for (i = 0; i < 2; i++) begin
			wr(`OFS_MODE, {30'h0, i[0], 1'b1});
			wr(`OFS_CMD, 32'h1);
			fork
				for (k = 0; k < 12000 && conv_active === 1'b1; k++) begin
					@(posedge aclk);
				end
				wr(`OFS_CMD, 32'h2);
			join
			e = i ? int'(105.0 * 200.0 / 2.048) : int'(28.5 * 200.0 / 1.024);
			// Free oscillator phase at the trigger trims up to one half cycle
			chk("start_delay", 32'h1, {31'h0, k >= e - 98 / (i + 1) - 4 &&
				k <= e + 4});
			chk("sleep_bias", 32'h0, {31'h0, exc_bias_en});
			chk("no_result", 32'h1, {31'h0, data_ready_n});
		end
		// Single shot, then sleep while converting
		wr(`OFS_MODE, 32'h18);
		wr(`OFS_CMD, 32'h1);
		chk("shot_bias", 32'h1, {31'h0, exc_bias_en});
		wr(`OFS_CMD, 32'h2);
		repeat (1500) @(posedge aclk);
		chk("finishing", 32'h1, {31'h0, conv_active});
		chk("early_ready", 32'h1, {31'h0, data_ready_n});
		rdc(`OFS_STAT, 32'h33, "pending");
		stop_test();
	end
endmodule : adc_conversion_and_frontend_ctrl_tb
`default_nettype wire
